// [design/scr_regs.sv]
`timescale 1ns/1ps
// system control register group: cpu control, watchdog, identity,
// timebase, configuration prom port and refresh interval timer
module scr_regs
   import scr_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // wishbone register bus
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // command fifo flow control
   input  wire logic [4:0]  cmd_fifo_level,
   output logic             cpu_wr_ready_q,
   // expansion bus access watch
   input  wire logic        exp_access_pend,
   output logic             exp_abort_q,
   // dma endian selection
   output logic             sys_little_q,
   output logic             io_ctrl_little_q,
   output logic             slot0_little_q,
   output logic             slot1_little_q,
   // watchdog
   input  wire logic        wdt_enable,
   output logic             machine_reset_q,
   // identity
   input  wire logic        eisa_present_b,
   // timebase
   output logic      [31:0] timebase_q,
   // configuration prom
   input  wire logic        boot_sck,
   input  wire logic        prom_di,
   output logic             prom_cs_q,
   output logic             prom_sck_q,
   output logic             prom_do_q,
   // refresh
   output logic             refresh_req_q
);
   // register access path
   scr_bus_if bus ();

   // bus adapter owns ack and read data flops
   scr_wb_slave u_wb (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o),
      .bus      (bus.adapter)
   );

   // ---------------- storage ----------------
   logic [31:0]           ctrl_q, ctrl_d;   // cpu control one
   logic [31:0]           div_q, div_d;     // timebase prescale and step
   logic [31:0]           prom_q, prom_d;   // prom port drive bits
   logic [31:0]           pre_q, pre_d;     // refresh preload
   logic [SCR_WDT_W-1:0]  wdt_q, wdt_d;     // watchdog count
   logic [SCR_REF_W-1:0]  rcnt_q, rcnt_d;   // refresh interval count
   logic [SCR_PS_W-1:0]   ps_q, ps_d;       // prescale phase
   logic [SCR_TB_W-1:0]   tb_d;             // timebase next
   logic [11:0]           tmo_q, tmo_d;     // expansion timeout count
   logic                  eisa_q;           // registered presence
   logic                  bsck_q;           // boot clock last level
   logic                  endian_done_q;    // first prom bit taken

   // ---------------- write decode ----------------
   logic wr_ctrl, wr_div, wr_prom, wr_pre, wr_wclr;
   assign wr_ctrl = bus.wr_stb & (bus.adr == SCR_CTRL_ADR);
   assign wr_div  = bus.wr_stb & (bus.adr == SCR_DIV_ADR);
   assign wr_prom = bus.wr_stb & (bus.adr == SCR_PROM_ADR);
   assign wr_pre  = bus.wr_stb & (bus.adr == SCR_PRE_ADR);
   // count location and clear location both clear, data ignored
   assign wr_wclr = bus.wr_stb & ((bus.adr == SCR_WCLR_ADR)
                                 | (bus.adr == SCR_WDT_ADR));

   // only the documented field bits can be stored
   assign ctrl_d = wr_ctrl ? scr_merge(ctrl_q, bus.wdata, bus.sel,
                                       SCR_CTRL_MSK) : ctrl_q;
   assign div_d  = wr_div ? scr_merge(div_q, bus.wdata, bus.sel,
                                      SCR_DIV_MSK) : div_q;
   // data-in bit is outside the mask, so writes to it are dropped
   assign prom_d = wr_prom ? scr_merge(prom_q, bus.wdata, bus.sel,
                                       SCR_PROM_MSK) : prom_q;
   assign pre_d  = wr_pre ? scr_merge(pre_q, bus.wdata, bus.sel,
                                      SCR_PRE_MSK) : pre_q;

   // ---------------- control fields ----------------
   logic [SCR_WM_W-1:0] wm;        // watermark field
   logic [4:0]          fifo_max;  // largest allowed occupancy
   logic                abort_en;  // expansion timeout enable
   assign wm       = ctrl_q[SCR_WM_LSB +: SCR_WM_W];
   assign fifo_max = SCR_FIFO_SPAN - {1'b0, wm};
   assign abort_en = ctrl_q[SCR_ABORT_BIT];

   // ---------------- refresh interval timer ----------------
   logic ref_zero;  // timer at zero this cycle
   assign ref_zero = (rcnt_q == '0);
   // reload on zero, otherwise step down once per clock
   assign rcnt_d = ref_zero ? pre_q[SCR_REF_W-1:0]
                            : rcnt_q - 16'h0001;

   // ---------------- watchdog ----------------
   logic wdt_wrap;  // count about to roll over to zero
   assign wdt_wrap = ref_zero & (wdt_q == '1);
   // clear beats the advance so a timely clear never resets the machine
   assign wdt_d = wr_wclr  ? '0
                : ref_zero ? wdt_q + 20'h0_0001
                : wdt_q;

   // ---------------- timebase ----------------
   logic ps_hit;  // prescale period complete
   // compare with >= so a smaller new divider cannot strand the phase
   assign ps_hit = (ps_q >= div_q[SCR_DIV_LSB +: SCR_PS_W]);
   assign ps_d   = ps_hit ? '0 : ps_q + 8'h01;
   assign tb_d   = ps_hit ? timebase_q
                   + {24'h00_0000, div_q[SCR_INC_LSB +: SCR_PS_W]}
                 : timebase_q;

   // ---------------- expansion bus timeout ----------------
   logic tmo_hit;  // pending access ran the full time
   assign tmo_hit = abort_en & exp_access_pend & (tmo_q == SCR_TMO_CYC);
   // with timeouts disabled the counter is held and never fires
   assign tmo_d = (!abort_en || !exp_access_pend || tmo_hit) ? '0
                : tmo_q + 12'h001;

   // ---------------- endian selection ----------------
   logic sys_le_d, bsck_rise;
   assign bsck_rise = boot_sck & ~bsck_q;
   // latch data on the first prom clock rise after each reset only
   assign sys_le_d = (bsck_rise & ~endian_done_q) ? prom_di
                   : sys_little_q;

   // ---------------- read mux ----------------
   logic [31:0] id_val, rd_val;
   assign id_val = {27'h000_0000, eisa_q, SCR_REVISION};
   // unmapped addresses and reserved bits read as zero
   assign rd_val =
        (bus.adr == SCR_CTRL_ADR) ? ctrl_q
      : (bus.adr == SCR_WDT_ADR)  ? {12'h000, wdt_q}
      : (bus.adr == SCR_ID_ADR)   ? id_val
      : (bus.adr == SCR_DIV_ADR)  ? div_q
      : (bus.adr == SCR_PROM_ADR) ? (prom_q
                                   | ({31'h0000_0000, prom_di} << SCR_SI_BIT))
      : (bus.adr == SCR_PRE_ADR)  ? pre_q
      : (bus.adr == SCR_RCNT_ADR) ? {16'h0000, rcnt_q}
      : (bus.adr == SCR_TB_ADR)   ? timebase_q
      : 32'h0000_0000;
   assign bus.rdata = rd_val;

   // ---------------- software registers ----------------
   // control fields reset to documented values
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= SCR_CTRL_RST;
         div_q  <= SCR_DIV_RST;
         prom_q <= SCR_PROM_RST;
         pre_q  <= SCR_PRE_RST;
      end else begin
         ctrl_q <= ctrl_d;
         div_q  <= div_d;
         prom_q <= prom_d;
         pre_q  <= pre_d;
      end
   end

   // ---------------- counters ----------------
   // refresh timer starts from the preload reset value
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rcnt_q     <= SCR_PRE_RST[SCR_REF_W-1:0];
         wdt_q      <= '0;
         ps_q       <= '0;
         timebase_q <= '0;
         tmo_q      <= '0;
      end else begin
         rcnt_q     <= rcnt_d;
         wdt_q      <= wdt_d;
         ps_q       <= ps_d;
         timebase_q <= tb_d;
         tmo_q      <= tmo_d;
      end
   end

   // ---------------- event outputs ----------------
   // one-cycle pulses: refresh burst, machine reset, bus abort
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         refresh_req_q   <= 1'b0;
         machine_reset_q <= 1'b0;
         exp_abort_q     <= 1'b0;
      end else begin
         refresh_req_q   <= ref_zero;
         // a clear in the same cycle cancels the wrap
         machine_reset_q <= wdt_enable & wdt_wrap & ~wr_wclr;
         exp_abort_q     <= tmo_hit;
      end
   end

   // ---------------- flow control ----------------
   // ready falls once occupancy reaches the programmed maximum
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cpu_wr_ready_q <= 1'b0;
      end else begin
         cpu_wr_ready_q <= ({1'b0, cmd_fifo_level} < {1'b0, fifo_max});
      end
   end

   // ---------------- endian outputs ----------------
   // per agent: fixed mode bit when its override is set, else system
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sys_little_q     <= 1'b0;
         io_ctrl_little_q <= 1'b0;
         slot0_little_q   <= 1'b0;
         slot1_little_q   <= 1'b0;
      end else begin
         sys_little_q     <= sys_le_d;
         io_ctrl_little_q <= ctrl_q[SCR_IOFX] ? ctrl_q[SCR_IOLE]
                                              : sys_little_q;
         slot0_little_q   <= ctrl_q[SCR_S0FX] ? ctrl_q[SCR_S0LE]
                                              : sys_little_q;
         slot1_little_q   <= ctrl_q[SCR_S1FX] ? ctrl_q[SCR_S1LE]
                                              : sys_little_q;
      end
   end

   // ---------------- boot prom capture ----------------
   // the catch happens once; later prom traffic by software is ignored
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bsck_q        <= 1'b0;
         endian_done_q <= 1'b0;
      end else begin
         bsck_q <= boot_sck;
         if (bsck_rise) begin
            endian_done_q <= 1'b1;
         end
      end
   end

   // ---------------- pins ----------------
   // prom pins follow the written bits directly; no sequencing here
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prom_cs_q  <= 1'b0;
         prom_sck_q <= 1'b0;
         prom_do_q  <= 1'b0;
         eisa_q     <= 1'b0;
      end else begin
         prom_cs_q  <= prom_d[SCR_CS_BIT];
         prom_sck_q <= prom_d[SCR_SCK_BIT];
         prom_do_q  <= prom_d[SCR_SO_BIT];
         eisa_q     <= ~eisa_present_b;
      end
   end

endmodule // scr_regs

// [design/scr_pkg.sv]
// Function
// - watermark holds 17 minus occupancy, resets 0xC
// - bit 4 enables expansion bus timeouts
// - bit 12 fixes io controller endian, bit 13
// - bit 14 fixes slot zero endian, bit 15
// - bit 16 fixes slot one endian, bit 17
// - 20-bit watchdog counts refresh bursts, resets zero
// - enabled watchdog wrap resets the whole machine
// - any write to clear location zeroes watchdog
// - identity read-only, revision in bits 3:0
// - identity bit 4 reports eisa presence pin
// - timebase advances every prescale plus one clocks
// - timebase adds step field, step resets 1
// - prom port drives select, clock, data out
// - prom port bit 4 returns prom data in
// - system endian from first prom bit at power-up
// - refresh timer counts down, reloads preload 0x0C30
// - refresh timer value readable in bits 15:0
package scr_pkg;
   // register byte addresses
   localparam logic [7:0] SCR_CTRL_ADR  = 8'h00;
   localparam logic [7:0] SCR_WDT_ADR   = 8'h04;
   localparam logic [7:0] SCR_WCLR_ADR  = 8'h08;
   localparam logic [7:0] SCR_ID_ADR    = 8'h0C;
   localparam logic [7:0] SCR_DIV_ADR   = 8'h10;
   localparam logic [7:0] SCR_PROM_ADR  = 8'h14;
   localparam logic [7:0] SCR_PRE_ADR   = 8'h18;
   localparam logic [7:0] SCR_RCNT_ADR  = 8'h1C;
   localparam logic [7:0] SCR_TB_ADR    = 8'h20;
   // writable field masks and reset values
   localparam logic [31:0] SCR_CTRL_MSK = 32'h0003_F01F;
   localparam logic [31:0] SCR_CTRL_RST = 32'h0000_000C;
   localparam logic [31:0] SCR_DIV_MSK  = 32'h0000_FFFF;
   localparam logic [31:0] SCR_DIV_RST  = 32'h0000_0104;
   localparam logic [31:0] SCR_PROM_MSK = 32'h0000_000E;
   localparam logic [31:0] SCR_PROM_RST = 32'h0000_0000;
   localparam logic [31:0] SCR_PRE_MSK  = 32'h0000_FFFF;
   localparam logic [31:0] SCR_PRE_RST  = 32'h0000_0C30;
   // field positions
   localparam int SCR_WM_LSB = 0, SCR_WM_W = 4, SCR_ABORT_BIT = 4;
   localparam int SCR_IOFX = 12, SCR_IOLE = 13, SCR_S0FX = 14;
   localparam int SCR_S0LE = 15, SCR_S1FX = 16, SCR_S1LE = 17;
   localparam int SCR_WDT_W = 20, SCR_REV_W = 4, SCR_EISA_BIT = 4;
   localparam int SCR_DIV_LSB = 0, SCR_INC_LSB = 8, SCR_PS_W = 8;
   localparam int SCR_CS_BIT = 1, SCR_SCK_BIT = 2, SCR_SO_BIT = 3;
   localparam int SCR_SI_BIT = 4, SCR_REF_W = 16, SCR_TB_W = 32;
   localparam logic [4:0] SCR_FIFO_SPAN = 5'h11;  // seventeen
   // revision code, arbitrary value
   localparam logic [3:0] SCR_REVISION = 4'h7;
   // expansion bus timeout length in cycles
   localparam logic [11:0] SCR_TMO_CYC = 12'h0_3FF;
   // one per byte lane: old value with lanes and fields replaced
   function automatic logic [31:0] scr_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel, input logic [31:0] fmsk);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & fmsk;
      return (old_v & ~m) | (new_v & m);
   endfunction
endpackage

// [design/scr_bus_if.sv]
`timescale 1ns/1ps
// register access path between bus adapter and register bank
interface scr_bus_if;
   logic        wr_stb;  // one-cycle write commit
   logic [7:0]  adr;     // aligned byte address
   logic [31:0] wdata;   // write data
   logic [3:0]  sel;     // byte lanes
   logic [31:0] rdata;   // read data for adr, zero when unmapped
   modport adapter (output wr_stb, output adr, output wdata, output sel,
                    input rdata);
   modport bank (input wr_stb, input adr, input wdata, input sel,
                 output rdata);
endinterface

// [design/scr_wb_slave.sv]
`timescale 1ns/1ps
// classic wishbone slave: ack one cycle after request, dropped next cycle
module scr_wb_slave
   import scr_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // wishbone
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // register side
   scr_bus_if.adapter       bus
);
   logic        req;     // fresh request, not yet answered
   logic        ack_d;
   logic [31:0] dat_d;

   // a request is answered once; the ack cycle blocks a second answer
   assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign ack_d = req;
   assign dat_d = (req & ~wb_we_i) ? bus.rdata : 32'h0000_0000;
   // write lands on the edge where the master samples ack
   assign bus.wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   assign bus.adr    = {wb_adr_i[7:2], 2'b00};
   assign bus.wdata  = wb_dat_i;
   assign bus.sel    = wb_sel_i;

   // ack and read data flops
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= ack_d;
         wb_dat_o <= dat_d;
      end
   end
endmodule // scr_wb_slave

// [test/scr_regs_sva.sv]
`timescale 1ns/1ps
// pin-level watcher for the register group; mirrors only what it must
module scr_regs_sva
   import scr_pkg::*;
(
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst_b,
   // register bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // side pins
   input wire logic [4:0]  cmd_fifo_level,
   input wire logic        cpu_wr_ready_q,
   input wire logic        exp_access_pend,
   input wire logic        exp_abort_q,
   input wire logic        sys_little_q,
   input wire logic        io_ctrl_little_q,
   input wire logic        slot0_little_q,
   input wire logic        slot1_little_q,
   input wire logic        wdt_enable,
   input wire logic        machine_reset_q,
   input wire logic [31:0] timebase_q,
   input wire logic        prom_cs_q,
   input wire logic        prom_sck_q,
   input wire logic        prom_do_q,
   input wire logic        refresh_req_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // a write lands at the edge where the master sees ack (full words only)
   wire         wr_hit  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   wire         wr_ctrl = wr_hit && wb_adr_i[7:2] == SCR_CTRL_ADR[7:2];
   wire         wr_div  = wr_hit && wb_adr_i[7:2] == SCR_DIV_ADR[7:2];
   wire         wr_pre  = wr_hit && wb_adr_i[7:2] == SCR_PRE_ADR[7:2];
   wire         wr_prom = wr_hit && wb_adr_i[7:2] == SCR_PROM_ADR[7:2];
   logic [31:0] ctrl_m;  // control mirror
   logic [15:0] div_m;   // divider mirror
   logic [15:0] pre_m;   // preload mirror
   logic [16:0] rf_gap;  // cycles since last refresh pulse
   logic [1:0]  rf_arm;  // first two intervals after a preload write are skipped
   // expected values derived from the mirrors; prom pin values come from the write data
   wire         rdy_x = cmd_fifo_level < (SCR_FIFO_SPAN - {1'b0, ctrl_m[3:0]});
   wire         ab_en = ctrl_m[SCR_ABORT_BIT];
   wire [2:0]   so_x  = wb_dat_i[3:1];
   wire [31:0]  inc_x = {24'h00_0000, div_m[15:8]};
   wire [2:0]   le_x  = {ctrl_m[SCR_S1FX] ? ctrl_m[SCR_S1LE] : sys_little_q,
                         ctrl_m[SCR_S0FX] ? ctrl_m[SCR_S0LE] : sys_little_q,
                         ctrl_m[SCR_IOFX] ? ctrl_m[SCR_IOLE] : sys_little_q};
   // mirrors follow committed writes; gap counter restarts on each burst
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_m <= SCR_CTRL_RST;
         div_m  <= SCR_DIV_RST[15:0];
         pre_m  <= SCR_PRE_RST[15:0];
         rf_gap <= 17'h0_0000;
         rf_arm <= 2'h0;
      end else begin
         if (wr_ctrl) ctrl_m <= wb_dat_i & SCR_CTRL_MSK;
         if (wr_div) div_m <= wb_dat_i[15:0];
         if (wr_pre) pre_m <= wb_dat_i[15:0];
         rf_gap <= refresh_req_q ? 17'h0_0001 : rf_gap + 17'h0_0001;
         rf_arm <= wr_pre ? 2'h0 : (refresh_req_q && rf_arm != 2'h2) ? rf_arm + 2'h1 : rf_arm;
      end
   end
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   chk_ack_timing: assert property (s_take |=> s_ack_once)
      else $error("ack not a single pulse one cycle after request");
   chk_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero outside ack");
   chk_ready_level: assert property ($past(rst_b) |-> cpu_wr_ready_q == $past(rdy_x))
      else $error("write ready does not follow fifo level");
   chk_abort_cause: assert property (exp_abort_q |-> $past(ab_en) && $past(exp_access_pend))
      else $error("abort without enable or pending access");
   chk_endian_sel: assert property ($past(rst_b) && $stable(le_x)
      |-> {slot1_little_q, slot0_little_q, io_ctrl_little_q} == le_x)
      else $error("dma endian selection wrong");
   chk_prom_pins: assert property (wr_prom |=>
      {prom_do_q, prom_sck_q, prom_cs_q} == $past(so_x))
      else $error("prom pins do not follow port write");
   chk_refresh_gap: assert property (refresh_req_q && rf_arm == 2'h2
      |-> rf_gap == {1'b0, pre_m} + 17'h0_0001)
      else $error("refresh interval not preload plus one");
   chk_tb_step: assert property ($past(rst_b) && $stable(inc_x)
      && timebase_q != $past(timebase_q) |-> timebase_q - $past(timebase_q) == inc_x)
      else $error("timebase step not the step field");
   chk_wdt_reset: assert property (machine_reset_q |-> $past(wdt_enable))
      else $error("machine reset with watchdog disabled");
endmodule // scr_regs_sva

// [test/scr_regs_bench.sv]
`timescale 1ns/1ps
// self-checking bench: register table loop, then hand-written cases
module scr_regs_bench;
   import scr_pkg::*;
   // design pins; apart from the clock and the blocking time-zero setup, inputs change only by non-blocking assignment at the edge
   logic        clk_sys, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, timebase_q, rd, t0;
   logic [4:0]  cmd_fifo_level;
   logic        cpu_wr_ready_q, exp_access_pend, exp_abort_q, sys_little_q, io_ctrl_little_q;
   logic        slot0_little_q, slot1_little_q, wdt_enable, machine_reset_q, eisa_present_b;
   logic        boot_sck, prom_di, prom_cs_q, prom_sck_q, prom_do_q, refresh_req_q;
   int          err_count, checks_done, n;
   // rows: write flag, address, write data, expected read back
   localparam logic [72:0] ROWS [12] = '{
      {1'b0, SCR_CTRL_ADR, 32'h0000_0000, 32'h0000_000C},
      {1'b0, SCR_WDT_ADR, 32'h0000_0000, 32'h0000_0000},
      {1'b0, SCR_ID_ADR, 32'h0000_0000, 32'h0000_0017},
      {1'b0, SCR_DIV_ADR, 32'h0000_0000, 32'h0000_0104},
      {1'b0, SCR_PROM_ADR, 32'h0000_0000, 32'h0000_0010},
      {1'b0, SCR_PRE_ADR, 32'h0000_0000, 32'h0000_0C30},
      {1'b0, 8'h24, 32'h0000_0000, 32'h0000_0000},
      {1'b1, SCR_ID_ADR, 32'hFFFF_FFFF, 32'h0000_0017},
      {1'b1, SCR_CTRL_ADR, 32'hFFFF_FFFF, 32'h0003_F01F},
      {1'b1, SCR_PROM_ADR, 32'hFFFF_FFFF, 32'h0000_001E},
      {1'b1, SCR_DIV_ADR, 32'hFFFF_FFFF, 32'h0000_FFFF},
      {1'b1, SCR_WCLR_ADR, 32'hFFFF_FFFF, 32'h0000_0000}};
   scr_regs i_scr_regs (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmd_fifo_level, .cpu_wr_ready_q,
      .exp_access_pend, .exp_abort_q, .sys_little_q, .io_ctrl_little_q, .slot0_little_q,
      .slot1_little_q, .wdt_enable, .machine_reset_q, .eisa_present_b, .timebase_q,
      .boot_sck, .prom_di, .prom_cs_q, .prom_sck_q, .prom_do_q, .refresh_req_q);
   // 250 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle; waits for ack without assuming its latency
   task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // only the hang guard ends a wait that never sees ack
      do begin
         @(posedge clk_sys);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask
   // count edges until a refresh (k=0) or abort (k=1) pulse, up to lim
   task automatic wait_ev(input logic k, input int lim, output int c);
      c = 0;
      do begin
         @(posedge clk_sys);
         c++;
      end while ((k ? exp_abort_q : refresh_req_q) !== 1'b1 && c < lim);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hang guard, well beyond the planned run of about 5.5k cycles
   initial begin
      #200_000;
      err_count++;
      $display("FAIL run time expected end seen timeout");
      wrap_up;
   end
   initial begin
      {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, exp_access_pend, boot_sck} = 6'h00;
      {wb_adr_i, wb_dat_i, cmd_fifo_level} = 45'h0;
      {wb_sel_i, wdt_enable, eisa_present_b, prom_di} = 7'h79;
      err_count = 0;
      checks_done = 0;
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      // one boot clock with prom data high selects little endian
      @(posedge clk_sys) boot_sck <= 1'b1;
      @(posedge clk_sys) boot_sck <= 1'b0;
      for (int i = 0; i < 12; i++) begin
         if (ROWS[i][72]) wb_xfer(1'b1, ROWS[i][71:64], ROWS[i][63:32], rd);
         wb_xfer(1'b0, ROWS[i][71:64], 32'h0000_0000, rd);
         chk($sformatf("row %0d", i), ROWS[i][31:0], rd);
      end
      $display("test register table done");
      repeat (3) @(posedge clk_sys);
      chk("system endian", 32'h1, sys_little_q);
      chk("fixed little", 32'h7, {slot1_little_q, slot0_little_q, io_ctrl_little_q});
      chk("prom pins", 32'h7, {prom_do_q, prom_sck_q, prom_cs_q});
      wb_xfer(1'b1, SCR_CTRL_ADR, 32'h0001_500C, rd);
      repeat (3) @(posedge clk_sys);
      chk("fixed big", 32'h0, {slot1_little_q, slot0_little_q, io_ctrl_little_q});
      wb_xfer(1'b1, SCR_CTRL_ADR, 32'h0000_000C, rd);
      repeat (3) @(posedge clk_sys);
      chk("follow system", 32'h7, {slot1_little_q, slot0_little_q, io_ctrl_little_q});
      cmd_fifo_level <= 5'h04;
      repeat (3) @(posedge clk_sys);
      chk("ready below mark", 32'h1, cpu_wr_ready_q);
      cmd_fifo_level <= 5'h05;
      repeat (3) @(posedge clk_sys);
      chk("ready at mark", 32'h0, cpu_wr_ready_q);
      $display("test endian and ready done");
      wb_xfer(1'b1, SCR_DIV_ADR, 32'h0000_0300, rd);
      repeat (3) @(posedge clk_sys);
      t0 = timebase_q;
      repeat (10) @(posedge clk_sys);
      chk("timebase step three", 32'h0000_001E, timebase_q - t0);
      wb_xfer(1'b1, SCR_DIV_ADR, 32'h0000_0104, rd);
      repeat (3) @(posedge clk_sys);
      t0 = timebase_q;
      repeat (50) @(posedge clk_sys);
      chk("timebase divide five", 32'h0000_000A, timebase_q - t0);
      $display("test timebase done");
      wb_xfer(1'b1, SCR_PRE_ADR, 32'h0000_0009, rd);
      wait_ev(1'b0, 4000, n);
      wait_ev(1'b0, 4000, n);
      chk("refresh interval", 32'h0000_000A, n);
      wb_xfer(1'b1, SCR_WCLR_ADR, 32'hA5A5_A5A5, rd);
      repeat (5) wait_ev(1'b0, 40, n);
      wb_xfer(1'b0, SCR_WDT_ADR, 32'h0000_0000, rd);
      chk("watchdog bursts", 32'h0000_0005, rd);
      wb_xfer(1'b0, SCR_RCNT_ADR, 32'h0000_0000, rd);
      chk("refresh count range", 32'h1, rd <= 32'h0000_0009);
      $display("test refresh and watchdog done");
      wb_xfer(1'b1, SCR_CTRL_ADR, 32'h0000_001C, rd);
      exp_access_pend <= 1'b1;
      wait_ev(1'b1, 1200, n);
      chk("abort when enabled", 32'h1, n < 1200);
      exp_access_pend <= 1'b0;
      wb_xfer(1'b1, SCR_CTRL_ADR, 32'h0000_000C, rd);
      exp_access_pend <= 1'b1;
      wait_ev(1'b1, 1200, n);
      chk("no abort when disabled", 32'h1, n >= 1200);
      exp_access_pend <= 1'b0;
      $display("test bus timeout done");
      // mid-run reset: preload returns, endian caught again, now big
      rst_b          <= 1'b0;
      prom_di        <= 1'b0;
      eisa_present_b <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys) boot_sck <= 1'b1;
      @(posedge clk_sys) boot_sck <= 1'b0;
      wb_xfer(1'b0, SCR_PRE_ADR, 32'h0000_0000, rd);
      chk("preload after reset", SCR_PRE_RST, rd);
      wb_xfer(1'b0, SCR_ID_ADR, 32'h0000_0000, rd);
      chk("identity no eisa", 32'h0000_0007, rd);
      wb_xfer(1'b0, SCR_PROM_ADR, 32'h0000_0000, rd);
      chk("prom data low", 32'h0000_0000, rd);
      chk("system big", 32'h0, sys_little_q);
      chk("no machine reset", 32'h0, machine_reset_q);
      $display("test reset and pins done");
      wrap_up;
   end
endmodule // scr_regs_bench
bind scr_regs scr_regs_sva i_scr_regs_sva (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmd_fifo_level, .cpu_wr_ready_q,
   .exp_access_pend, .exp_abort_q, .sys_little_q, .io_ctrl_little_q, .slot0_little_q,
   .slot1_little_q, .wdt_enable, .machine_reset_q, .timebase_q, .prom_cs_q, .prom_sck_q,
   .prom_do_q, .refresh_req_q);
